// [src/dgo_pkg.sv]
// Shared constants for the memory device and controller ends
package dgo_pkg;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned ROW_W = 14;
  localparam int unsigned COL_W = 10;
  localparam int unsigned BANKS_X16 = 8;
  localparam int unsigned BANKS_X4X8 = 16;
  localparam int unsigned PREFETCH = 8;
  localparam int unsigned CORE_CLKS = 4;
  localparam int unsigned TOGGLE_REFI = 8192;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned REFI_NS = 7800;
  localparam int unsigned REFI_CYC = REFI_NS / CLK_NS;
  localparam int unsigned TEMP_HOT_C = 85;
  localparam int unsigned ADDR_W = 17;
  localparam logic [2:0] CMD_DES = 3'h0;
  localparam logic [2:0] CMD_NOP = 3'h1;
  localparam logic [2:0] CMD_ACT = 3'h2;
  localparam logic [2:0] CMD_RD = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_REF = 3'h5;
  localparam logic [2:0] CMD_PRE = 3'h6;
  // Encoding on ras_n, cas_n, we_n when activate is high
  localparam logic [2:0] ENC_NOP = 3'h7;
  localparam logic [2:0] ENC_RD = 3'h5;
  localparam logic [2:0] ENC_WR = 3'h4;
  localparam logic [2:0] ENC_REF = 3'h1;
  localparam logic [2:0] ENC_PRE = 3'h2;
  localparam logic [1:0] ODT_OFF = 2'h0;
endpackage

// [src/dgo_if.sv]
// Command, address and data link between controller and memory device
`timescale 1ns/100ps
interface dgo_if;
  logic cke;
  logic cs_n;
  logic act_n;
  logic [dgo_pkg::ADDR_W-1:0] addr;
  logic [3:0] bank;
  logic odt;
  logic [dgo_pkg::DQ_W-1:0] dq_rise_h;
  logic [dgo_pkg::DQ_W-1:0] dq_fall_h;
  logic dq_oe_n_h;
  logic [dgo_pkg::DQ_W-1:0] dq_rise_d;
  logic [dgo_pkg::DQ_W-1:0] dq_fall_d;
  logic dq_oe_n_d;
  logic dq_term_d;
  modport device (
    input cke, cs_n, act_n, addr, bank, odt, dq_rise_h, dq_fall_h, dq_oe_n_h,
    output dq_rise_d, dq_fall_d, dq_oe_n_d, dq_term_d
  );
  modport host (
    output cke, cs_n, act_n, addr, bank, odt, dq_rise_h, dq_fall_h, dq_oe_n_h,
    input dq_rise_d, dq_fall_d, dq_oe_n_d, dq_term_d
  );
endinterface

// [src/dgo_device.sv]
// Memory device end: command decode, banks, prefetch burst engine
`timescale 1ns/100ps
// Notes on behaviour
// - Eight banks on x16, sixteen otherwise
// - Eight-word prefetch, two pin words per clock
// - Each access: 8n core word over four clocks
// - Controller doubles refresh rate above 85C
// - Controller idles with deselect; no-op only while mps_exit_i is high or as the select toggle
// - Controller toggles clock enable each 8191 refreshes
// - With enable fixed high, toggle select instead
// - Idle pins tri-stated or terminated per setting
// - Inputs sampled on rising true clock
// - Activate low turns command pins into row bits
module dgo_device #(
  parameter int unsigned DQ_W = dgo_pkg::DQ_W,
  parameter int unsigned X16 = 1,
  parameter int unsigned MEM_COLS = 64
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic odt_term_en_i,
  output logic [4:0] bank_count_o,
  output logic [15:0] open_banks_o,
  output logic busy_o,
  dgo_if.device link
);
  localparam int unsigned NBANK = (X16 != 0) ? dgo_pkg::BANKS_X16 : dgo_pkg::BANKS_X4X8;
  // One core word holds a whole burst: eight pin words of the data width
  localparam int unsigned PREFETCH_BITS = dgo_pkg::PREFETCH * DQ_W;
  // Beat that closes a burst; four core clocks per access
  localparam logic [1:0] BEAT_LAST = 2'(dgo_pkg::CORE_CLKS - 1);
  typedef enum logic [1:0] {DGO_IDLE, DGO_READ, DGO_WRITE} dgo_state_t;

  // Small storage array per bank and column, 8n words (prefetch)
  // Kept tiny on purpose: only enough columns to tell bursts apart
  logic [PREFETCH_BITS-1:0] mem_q [NBANK*MEM_COLS];

  dgo_state_t state_q, state_d;
  logic [1:0] beat_q, beat_d;
  logic [PREFETCH_BITS-1:0] word_q, word_d;
  logic [$clog2(NBANK*MEM_COLS)-1:0] idx_q, idx_d;
  logic [15:0] open_q, open_d;
  logic [DQ_W-1:0] rise_q, rise_d, fall_q, fall_d;
  logic oe_n_q, oe_n_d;
  logic wr_en;
  logic [2:0] enc;
  logic [3:0] bsel; // Bank after folding onto the real bank count

  // Decode only when selected; activate low means row bits
  function automatic logic [2:0] dgo_decode(input logic cs_n, input logic act_n,
                                            input logic [2:0] e);
    if (cs_n) begin
      return dgo_pkg::CMD_DES;
    end else if (!act_n) begin
      return dgo_pkg::CMD_ACT;
    end else begin
      case (e)
        dgo_pkg::ENC_RD: return dgo_pkg::CMD_RD;
        dgo_pkg::ENC_WR: return dgo_pkg::CMD_WR;
        dgo_pkg::ENC_REF: return dgo_pkg::CMD_REF;
        dgo_pkg::ENC_PRE: return dgo_pkg::CMD_PRE;
        default: return dgo_pkg::CMD_NOP;
      endcase
    end
  endfunction

  // Fold the bank pins onto the banks this organisation really has
  // Upper bank bits are ignored on the eight-bank build, not refused
  function automatic logic [3:0] dgo_bank(input logic [3:0] b);
    return 4'(b % NBANK);
  endfunction

  assign enc = link.addr[16:14];
  assign bsel = dgo_bank(link.bank);
  assign bank_count_o = 5'(NBANK);
  // A command during a burst is ignored, so the host must count the beats
  assign busy_o = (state_q != DGO_IDLE);

  // Bits above the bank count stay low on the eight-bank build
  for (genvar i = 0; i < 16; i++) begin : g_open
    if (i < NBANK) begin : g_used
      assign open_banks_o[i] = open_q[i];
    end else begin : g_unused
      assign open_banks_o[i] = 1'b0;
    end
  end

  // Next state: commands taken on the rising edge, with clock enable high
  always_comb begin
    logic [2:0] cmd;
    cmd = dgo_pkg::CMD_DES;
    state_d = state_q;
    beat_d = beat_q;
    word_d = word_q;
    idx_d = idx_q;
    open_d = open_q;
    rise_d = rise_q;
    fall_d = fall_q;
    oe_n_d = 1'b1;
    wr_en = 1'b0;
    if (link.cke) begin
      cmd = dgo_decode(link.cs_n, link.act_n, enc);
    end
    case (state_q)
      // Idle: take a command, open or close rows, or start a burst
      DGO_IDLE: begin
        beat_d = 2'h0;
        // Column index is latched every idle cycle; the burst keeps the last one
        idx_d = ($bits(idx_q))'(bsel * MEM_COLS + (link.addr % MEM_COLS));
        case (cmd)
          dgo_pkg::CMD_ACT: open_d[bsel] = 1'b1;
          dgo_pkg::CMD_PRE: begin
            // Address bit 10 high closes every bank at once
            if (link.addr[10]) begin
              open_d = 16'h0000;
            end else begin
              open_d[bsel] = 1'b0;
            end
          end
          // Read or write to a closed bank is refused and leaves us idle
          dgo_pkg::CMD_RD: begin
            if (open_q[bsel]) begin
              state_d = DGO_READ;
              word_d = mem_q[idx_d];
            end
          end
          dgo_pkg::CMD_WR: begin
            if (open_q[bsel]) begin
              state_d = DGO_WRITE;
              word_d = '0;
            end
          end
          default: begin
            // Refresh, no-op and deselect leave the rows as they are
            open_d = open_q;
          end
        endcase
      end
      DGO_READ: begin
        // Two words per clock, rise then fall half
        // Pins are registered, so data shows one cycle after each beat
        rise_d = word_q[(2*beat_q)*DQ_W +: DQ_W];
        fall_d = word_q[(2*beat_q+1)*DQ_W +: DQ_W];
        oe_n_d = 1'b0;
        beat_d = beat_q + 2'h1;
        if (beat_q == BEAT_LAST) begin
          state_d = DGO_IDLE;
        end
      end
      DGO_WRITE: begin
        // Host words land straight in the core word, low pair first
        word_d[(2*beat_q)*DQ_W +: DQ_W] = link.dq_rise_h;
        word_d[(2*beat_q+1)*DQ_W +: DQ_W] = link.dq_fall_h;
        beat_d = beat_q + 2'h1;
        if (beat_q == BEAT_LAST) begin
          wr_en = 1'b1;
          state_d = DGO_IDLE;
        end
      end
      default: state_d = DGO_IDLE;
    endcase
  end

  // Registers for control and pin drivers
  // Data pins reset to zero with the driver off, so nothing is driven
  // before the first read
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= DGO_IDLE;
      beat_q <= 2'h0;
      word_q <= '0;
      idx_q <= '0;
      open_q <= 16'h0000;
      rise_q <= '0;
      fall_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      beat_q <= beat_d;
      word_q <= word_d;
      idx_q <= idx_d;
      open_q <= open_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Storage has no reset; contents are undefined after power-up anyway
  // Write lands on the last beat, using the word completed that cycle
  always_ff @(posedge clock_i) begin
    if (wr_en) begin
      mem_q[idx_q] <= word_d;
    end
  end

  // Not driving: terminate only if enabled by setting and strobe, else tri-state
  // Termination follows the host's strobe, which stays high while it
  // is not driving; the setting input stands for the mode register choice.
  // Never terminates while our own drivers are on, so no fight on the bus.
  assign link.dq_rise_d = rise_q;
  assign link.dq_fall_d = fall_q;
  assign link.dq_oe_n_d = oe_n_q;
  assign link.dq_term_d = oe_n_q & odt_term_en_i & link.odt;
endmodule

// [src/dgo_host.sv]
// Controller end: issues commands, bursts, refresh and idle duties
`timescale 1ns/100ps
module dgo_host #(
  parameter int unsigned DQ_W = dgo_pkg::DQ_W,
  parameter int unsigned REFI_CYC = dgo_pkg::REFI_CYC,
  parameter int unsigned TOGGLE_REFI = dgo_pkg::TOGGLE_REFI
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  input wire logic [2:0] req_cmd_i,
  input wire logic [3:0] req_bank_i,
  input wire logic [16:0] req_addr_i,
  input wire logic [8*DQ_W-1:0] req_wdata_i,
  input wire logic hot_i,
  input wire logic cke_fixed_i,
  input wire logic mps_exit_i,
  output logic req_ready_o,
  output logic [8*DQ_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic hi_temp_sr_o,
  dgo_if.host link
);
  localparam int unsigned TW = $clog2(TOGGLE_REFI + 1);
  typedef enum logic [1:0] {DGH_IDLE, DGH_WRITE, DGH_READ} dgh_state_t;

  dgh_state_t state_q, state_d;
  logic [1:0] beat_q, beat_d;
  logic [8*DQ_W-1:0] buf_q, buf_d;
  logic [31:0] refi_q, refi_d;
  logic [TW-1:0] tog_q, tog_d;
  logic cke_q, cke_d;
  logic rd_valid_q, rd_valid_d;
  logic cs_n, act_n, oe_n;
  logic [16:0] addr;
  logic [DQ_W-1:0] rise, fall;
  logic ref_due, tog_due;
  logic [31:0] refi_lim;

  // Above the hot limit refresh interval halves
  assign refi_lim = hot_i ? 32'(REFI_CYC / 2) : 32'(REFI_CYC);
  assign hi_temp_sr_o = hot_i;
  assign ref_due = (refi_q >= refi_lim - 32'h1);
  // At or past the limit: a refresh may step over the exact count
  assign tog_due = (tog_q >= TW'(TOGGLE_REFI - 1));
  assign req_ready_o = (state_q == DGH_IDLE) && cke_q && !ref_due && !tog_due;
  assign rd_data_o = buf_q;
  assign rd_valid_o = rd_valid_q;

  // Command drive and sequencing
  always_comb begin
    state_d = state_q;
    beat_d = beat_q;
    buf_d = buf_q;
    refi_d = refi_q + 32'h1;
    tog_d = tog_q;
    cke_d = 1'b1;
    rd_valid_d = 1'b0;
    cs_n = 1'b1; // Idle is deselect
    act_n = 1'b1;
    addr = {dgo_pkg::ENC_NOP, 14'h0000};
    oe_n = 1'b1;
    rise = '0;
    fall = '0;
    case (state_q)
      DGH_IDLE: begin
        if (!cke_q) begin
          // Enable is low this cycle; any command now would be lost
          cs_n = 1'b1;
        end else if (ref_due) begin
          // Counters move only once the refresh is really on the pins
          cs_n = 1'b0;
          addr = {dgo_pkg::ENC_REF, 14'h0000};
          refi_d = 32'h0;
          tog_d = tog_q + TW'(1);
        end else if (tog_due) begin
          // Periodic toggle; select pulse if enable must stay high
          tog_d = '0;
          if (cke_fixed_i) begin
            cs_n = 1'b0;
          end else begin
            cke_d = 1'b0;
          end
        end else if (mps_exit_i) begin
          cs_n = 1'b0;
        end else if (req_valid_i) begin
          cs_n = 1'b0;
          addr = req_addr_i;
          case (req_cmd_i)
            dgo_pkg::CMD_ACT: act_n = 1'b0;
            dgo_pkg::CMD_RD: begin
              addr[16:14] = dgo_pkg::ENC_RD;
              state_d = DGH_READ;
            end
            dgo_pkg::CMD_WR: begin
              addr[16:14] = dgo_pkg::ENC_WR;
              buf_d = req_wdata_i;
              state_d = DGH_WRITE;
            end
            dgo_pkg::CMD_PRE: addr[16:14] = dgo_pkg::ENC_PRE;
            default: cs_n = 1'b1;
          endcase
          beat_d = 2'h0;
        end
      end
      DGH_WRITE: begin
        oe_n = 1'b0;
        rise = buf_q[(2*beat_q)*DQ_W +: DQ_W];
        fall = buf_q[(2*beat_q+1)*DQ_W +: DQ_W];
        beat_d = beat_q + 2'h1;
        if (beat_q == 2'h3) begin
          state_d = DGH_IDLE;
        end
      end
      DGH_READ: begin
        // Device drives two cycles after the command clock
        if (!link.dq_oe_n_d) begin
          buf_d[(2*beat_q)*DQ_W +: DQ_W] = link.dq_rise_d;
          buf_d[(2*beat_q+1)*DQ_W +: DQ_W] = link.dq_fall_d;
          beat_d = beat_q + 2'h1;
          if (beat_q == 2'h3) begin
            rd_valid_d = 1'b1;
            state_d = DGH_IDLE;
          end
        end
      end
      default: state_d = DGH_IDLE;
    endcase
  end

  // Registered state
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= DGH_IDLE;
      beat_q <= 2'h0;
      buf_q <= '0;
      refi_q <= 32'h0;
      tog_q <= '0;
      cke_q <= 1'b0;
      rd_valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      beat_q <= beat_d;
      buf_q <= buf_d;
      refi_q <= refi_d;
      tog_q <= tog_d;
      cke_q <= cke_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign link.cke = cke_q;
  assign link.cs_n = cs_n;
  assign link.act_n = act_n;
  assign link.addr = addr;
  assign link.bank = req_bank_i;
  assign link.odt = oe_n;
  assign link.dq_rise_h = rise;
  assign link.dq_fall_h = fall;
  assign link.dq_oe_n_h = oe_n;
endmodule

// [bench/dgo_props.sv]
// Checker watching the controller to device link
`timescale 1ns/100ps
module dgo_props #(
  parameter int unsigned REFI_CYC = dgo_pkg::REFI_CYC,
  parameter int unsigned TOGGLE_REFI = dgo_pkg::TOGGLE_REFI
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic cke_fixed_i,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic [dgo_pkg::ADDR_W-1:0] addr,
  input wire logic dq_oe_n_h,
  input wire logic dq_oe_n_d
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Slack covers a refresh or toggle slot held back by a burst
  localparam int unsigned LIM_REF = REFI_CYC + 8;
  localparam int unsigned LIM_TOG = TOGGLE_REFI * REFI_CYC + 8;
  logic sel;
  logic rd_cmd;
  logic wr_cmd;
  logic ref_cmd;
  logic [31:0] ref_q, ref_d, cke_q, cke_d, cs_q, cs_d;
  // Command decode, only valid with select low and activate high
  assign sel = cke && !cs_n && act_n;
  assign rd_cmd = sel && addr[16:14] == dgo_pkg::ENC_RD;
  assign wr_cmd = sel && addr[16:14] == dgo_pkg::ENC_WR;
  assign ref_cmd = sel && addr[16:14] == dgo_pkg::ENC_REF;
  // Cycles since the last refresh, enable low and select low
  always_comb begin
    ref_d = ref_cmd ? 32'h0 : ref_q + 32'h1;
    cke_d = (!cke || cke_fixed_i) ? 32'h0 : cke_q + 32'h1;
    cs_d = !cs_n ? 32'h0 : cs_q + 32'h1;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_q <= 32'h0;
      cke_q <= 32'h0;
      cs_q <= 32'h0;
    end else begin
      ref_q <= ref_d;
      cke_q <= cke_d;
      cs_q <= cs_d;
    end
  end
  chk_read_burst: assert property (
    $fell(dq_oe_n_d) |-> !dq_oe_n_d [*4] ##1 dq_oe_n_d) else $error("read burst length wrong");
  chk_read_cause: assert property (
    $fell(dq_oe_n_d) |-> $past(rd_cmd, 2)) else $error("device drove data without read");
  chk_write_burst: assert property (
    $fell(dq_oe_n_h) |-> !dq_oe_n_h [*4] ##1 dq_oe_n_h) else $error("write burst length wrong");
  chk_write_cause: assert property (
    $fell(dq_oe_n_h) |-> $past(wr_cmd)) else $error("host drove data without write");
  chk_bus_owner: assert property (
    dq_oe_n_d || dq_oe_n_h) else $error("both ends drive data");
  chk_refresh_gap: assert property (
    ref_q <= LIM_REF) else $error("refresh interval too long");
  chk_cke_toggle: assert property (
    cke_q <= LIM_TOG) else $error("clock enable not toggled");
  chk_cs_toggle: assert property (
    cs_q <= LIM_TOG) else $error("select not toggled");
  // Main traffic kinds
  cover property ($fell(dq_oe_n_d));
  cover property ($fell(dq_oe_n_h));
  cover property (ref_cmd);
  cover property ($fell(cke));
endmodule

// [bench/ddr4_sdram_general_operation_tb.sv]
// Self-checking bench joining controller and device ends
`timescale 1ns/100ps
module ddr4_sdram_general_operation_tb;
  localparam int unsigned REFI = 16;
  localparam int unsigned TOG = 4;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic odt_term_en_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic [2:0] req_cmd_i = 3'h0;
  logic [3:0] req_bank_i = 4'h0;
  logic [16:0] req_addr_i = 17'h0;
  logic [127:0] req_wdata_i = 128'h0;
  logic hot_i = 1'b0;
  logic cke_fixed_i = 1'b0;
  logic mps_exit_i = 1'b0;
  logic req_ready_o, rd_valid_o, hi_temp_sr_o;
  logic [127:0] rd_data_o;
  logic [4:0] bank_count_o;
  logic [15:0] open_banks_o;
  logic [127:0] mem [int];
  int failures = 0;
  int n_checks = 0;
  int seed = 40;
  int ref_n, nop_n, ckl_n;
  dgo_if link_if ();
  dgo_device dgo_device_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .odt_term_en_i(odt_term_en_i),
    .bank_count_o(bank_count_o), .open_banks_o(open_banks_o), .busy_o(), .link(link_if));
  dgo_host #(.REFI_CYC(REFI), .TOGGLE_REFI(TOG)) dgo_host_inst (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_bank_i(req_bank_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .hot_i(hot_i), .cke_fixed_i(cke_fixed_i),
    .mps_exit_i(mps_exit_i), .req_ready_o(req_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .hi_temp_sr_o(hi_temp_sr_o), .link(link_if));
  dgo_props #(.REFI_CYC(REFI), .TOGGLE_REFI(TOG)) dgo_props_inst (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .cke_fixed_i(cke_fixed_i), .cke(link_if.cke), .cs_n(link_if.cs_n),
    .act_n(link_if.act_n), .addr(link_if.addr), .dq_oe_n_h(link_if.dq_oe_n_h),
    .dq_oe_n_d(link_if.dq_oe_n_d));
  always #5 clock_i = ~clock_i;
  // Link monitor on the falling edge, clear of register updates
  always @(negedge clock_i) begin
    if (link_if.cke === 1'b1 && link_if.cs_n === 1'b0 && link_if.act_n === 1'b1) begin
      if (link_if.addr[16:14] === dgo_pkg::ENC_REF) ref_n++;
      if (link_if.addr[16:14] === dgo_pkg::ENC_NOP) nop_n++;
    end
    if (link_if.cke === 1'b0) ckl_n++;
  end
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Holds the request until ready is seen; valid is left high for back to back use
  task automatic req(input logic [2:0] c, input logic [3:0] b, input logic [16:0] a,
                     input logic [127:0] w);
    int n;
    n = 0;
    req_cmd_i = c;
    req_bank_i = b;
    req_addr_i = a;
    req_wdata_i = w;
    req_valid_i = 1'b1;
    @(negedge clock_i);
    while (req_ready_o !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    cmp(req_ready_o, 1'b1);
    @(posedge clock_i);
    #1;
  endtask
  // Read one column and check every beat on the wire
  task automatic rd(input logic [3:0] b, input logic [5:0] c);
    logic [127:0] e;
    int k;
    int n;
    e = mem[b * 64 + c];
    k = 0;
    n = 0;
    req(dgo_pkg::CMD_RD, b, {11'h0, c}, 128'h0);
    req_valid_i = 1'b0;
    while (rd_valid_o !== 1'b1 && n < 40) begin
      if (link_if.dq_oe_n_d === 1'b0) begin
        cmp({link_if.dq_fall_d, link_if.dq_rise_d}, e[32*k+:32]);
        k++;
      end else cmp(link_if.dq_term_d, odt_term_en_i);
      @(posedge clock_i);
      #1;
      n++;
    end
    cmp(rd_data_o, e);
    cmp(k, 4);
  endtask
  initial begin
    logic [5:0] col [4];
    logic [127:0] w;
    repeat (12) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    cmp(bank_count_o, 5'h08);
    // Activate then write banks 0 to 3 with no gap between requests
    for (int b = 0; b < 4; b++) begin
      col[b] = 6'($random(seed));
      w = {$random(seed), $random(seed), $random(seed), $random(seed)};
      mem[b * 64 + col[b]] = w;
      req(dgo_pkg::CMD_ACT, 4'(b), 17'($random(seed)) & 17'h3FFF, 128'h0);
      req(dgo_pkg::CMD_WR, 4'(b), {11'h0, col[b]}, w);
    end
    req_valid_i = 1'b0;
    repeat (8) @(posedge clock_i);
    #1;
    cmp(open_banks_o, 16'h000F);
    for (int b = 3; b >= 0; b--) rd(4'(b), col[b]);
    odt_term_en_i = 1'b0;
    rd(4'h0, col[0]);
    // Close one bank, then all banks with address bit 10
    req(dgo_pkg::CMD_PRE, 4'h0, 17'h00000, 128'h0);
    cmp(open_banks_o, 16'h000E);
    req(dgo_pkg::CMD_PRE, 4'h1, 17'h00400, 128'h0);
    req_valid_i = 1'b0;
    cmp(open_banks_o, 16'h0000);
    // Cold then hot refresh windows
    for (int h = 0; h < 2; h++) begin
      hot_i = 1'(h);
      ref_n = 0;
      nop_n = 0;
      ckl_n = 0;
      repeat (320) @(posedge clock_i);
      #1;
      cmp(hi_temp_sr_o, hot_i);
      cmp(ref_n >= (20 << h) - 2 && ref_n <= (20 << h) + 2, 1'b1);
      cmp(nop_n, 0);
      cmp(ckl_n >= 4, 1'b1);
    end
    mps_exit_i = 1'b1;
    nop_n = 0;
    repeat (20) @(posedge clock_i);
    #1;
    mps_exit_i = 1'b0;
    cmp(nop_n > 0, 1'b1);
    // Enable held high: select must toggle instead
    cke_fixed_i = 1'b1;
    repeat (4) @(posedge clock_i);
    ckl_n = 0;
    repeat (160) @(posedge clock_i);
    #1;
    cmp(ckl_n, 0);
    summarize();
  end
  // Run needs about ten microseconds; ten times that means a hang
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule
